// ===== rtl/ipb_core.sv
// Instruction prefetch buffer: eight byte sections, shift network, input
// mux with cache fill, prefetch request logic and a Wishbone register slave.
// Assumes cache_grant is same-clock logic that returns the longword at
// cache_addr in the cycle it is asserted while cache_req is high.
//
// Summary of operation
// RQ1 - Eight sections: data byte plus valid
// RQ2 - Section 0 holds lowest address
// RQ3 - Every section reloads each clock edge; here only on edges with ce high, all sections hold while ce is low
// RQ4 - Shift sections down by 0,1,2,4
// RQ5 - Decode all sixteen control field values
// RQ6 - Code 0 leaves everything unchanged
// RQ7 - Code 1 stops prefetch requests
// RQ8 - Code 2 flushes, loads fetch address
// RQ9 - Code 3 resumes prefetch requests
// RQ10 - Code 4 discards sections 0,1
// RQ11 - Code 5 discards sections 2,3
// RQ12 - Code 7 extracts branch target
// RQ13 - Code C discards section 0
// RQ14 - Code D discards specifier section 1
// RQ15 - Code E discards sections 0 to 3
// RQ16 - Code F discards 1,2,4 data bytes
// RQ17 - Code F without data drops specifier
// RQ18 - Valid shifted byte beats cache byte
// RQ19 - Cache data passes byte rotator
// RQ20 - Low address bits pick rotation
// RQ21 - Unused codes act as no-op
// RQ22 - Request while enabled and not full
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ipb_core import ipb_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [3:0] buffer_control_field,
	input wire logic [31:0] new_fetch_addr,
	input wire logic [1:0] stream_ctx_size,
	input wire logic cache_grant,
	input wire logic [31:0] cache_data,
	output logic cache_req,
	output logic [31:0] cache_addr,
	output ipb_buf_t buf_out,
	output logic [31:0] virtual_fetch_address,
	output logic [31:0] branch_target_extract,
	output logic branch_target_valid,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [31:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_wdat,
	output logic [31:0] wb_rdat,
	output logic wb_ack
);

	ipb_buf_t buf_q, buf_d, shf;
	ipb_ctl_t ctl;
	ipb_shf_t sel;
	logic [2:0] lo;
	logic [31:0] addr_q, addr_d, vfa_q, rot, bt_q;
	logic pf_en_q, pf_en_d, allow_q, req_q, req_d, bt_vld_q, ack_q;
	logic [31:0] cache_addr_q, rdat_q;
	logic take, flush, wb_go, ctrl_wr, allow_d;
	logic [3:0] gap, nb, taken;
	logic [7:0] spec;

	assign ctl = ipb_ctl_t'(buffer_control_field);
	assign flush = (ctl == IPB_FLUSH);
	assign take = req_q && cache_grant && !flush;
	assign spec = buf_q[1].dat;

	// Control field decode into shift low mark and distance
	// Discard codes trust microcode to drop only sections that are valid
	always_comb begin
		lo = 3'h0;
		sel = IPB_SH0;
		unique case (ctl) // RQ5
			IPB_CLR01: begin
				sel = IPB_SH2; // RQ10
			end
			IPB_CLR23: begin
				lo = 3'h2;
				sel = IPB_SH2; // RQ11
			end
			IPB_CLR0: begin
				sel = IPB_SH1; // RQ13
			end
			IPB_CLR1: begin
				lo = 3'h1;
				sel = IPB_SH1; // RQ14
			end
			IPB_CLR0123: begin
				sel = IPB_SH4; // RQ15
			end
			IPB_CLRCOND: begin
				lo = 3'h1;
				// Data length from the specifier mode nibble
				// Only the specifier is decoded here; operand size arrives from outside
				unique case (spec[7:4])
					4'hA, 4'hB: sel = IPB_SH1; // RQ16
					4'hC, 4'hD: sel = IPB_SH2; // RQ16
					4'hE, 4'hF: sel = IPB_SH4; // RQ16
					4'h9: sel = (spec[3:0] == 4'hF) ? IPB_SH4 : IPB_SH1;
					4'h8: begin
						if (spec[3:0] != 4'hF) begin
							sel = IPB_SH1; // RQ17
						end else if (stream_ctx_size == 2'b00) begin
							sel = IPB_SH1;
						end else if (stream_ctx_size == 2'b01) begin
							sel = IPB_SH2;
						end else begin
							sel = IPB_SH4;
						end
					end
					default: sel = IPB_SH1; // RQ17
				endcase
			end
			IPB_NOP, IPB_STOP, IPB_FLUSH, IPB_START, IPB_BDEST,
			IPB_UNUSED6, IPB_UNUSED8, IPB_UNUSED9, IPB_UNUSEDA, IPB_UNUSEDB: begin
				sel = IPB_SH0; // RQ6 RQ21
			end
		endcase
	end

	// Shift network
	ipb_shifter u_shifter (
		.cur(buf_q),
		.lo(lo),
		.sel(sel),
		.nxt(shf)
	);

	// Cache longword rotated to the current byte address
	ipb_rotator u_rotator (
		.lw(cache_data),
		.ofs(addr_q[1:0]),
		.rot(rot)
	); // RQ19 RQ20

	// Bytes available in the longword and bytes that fit
	assign gap = ipb_first_gap(shf);
	assign nb = IPB_BYTES_LW - {2'b00, addr_q[1:0]};
	assign taken = !take ? 4'h0 : ((nb > (IPB_NSECT - gap)) ? (IPB_NSECT - gap) : nb);

	// Input mux per section: valid shifted byte first, else cache byte
	always_comb begin
		logic [3:0] k;
		k = 4'h0;
		for (int i = 0; i < 8; i++) begin
			k = 4'(i) - gap;
			if (flush) begin
				buf_d[i] = '{vld: 1'b0, dat: shf[i].dat}; // RQ8
			end else if (shf[i].vld) begin
				buf_d[i] = shf[i]; // RQ18
			end else if (4'(i) >= gap && k < taken) begin
				// Rising section number follows rising address
				buf_d[i] = '{vld: 1'b1, dat: rot[{k[1:0], 3'b000} +: 8]}; // RQ2 RQ18 RQ22
			end else begin
				buf_d[i] = shf[i];
			end
		end
	end

	// Buffer register: reloaded on every enabled edge, holding comes from the mux
	always_ff @(posedge clk) begin
		if (!nrst) begin
			buf_q <= '0;
		end else if (ce) begin
			buf_q <= buf_d; // RQ1 RQ3
		end
	end

	// Byte fetch address advances by bytes accepted; flush reloads it
	assign addr_d = flush ? new_fetch_addr : (addr_q + {28'h0, taken});
	always_ff @(posedge clk) begin
		if (!nrst) begin
			addr_q <= IPB_RST_ADDR;
			vfa_q <= IPB_RST_ADDR;
		end else if (ce) begin
			addr_q <= addr_d;
			if (flush) begin
				vfa_q <= new_fetch_addr; // RQ8
			end
		end
	end

	// Prefetch enable: stop and start codes
	always_comb begin
		pf_en_d = pf_en_q;
		if (ctl == IPB_STOP) begin
			pf_en_d = 1'b0; // RQ7
		end else if (ctl == IPB_START) begin
			pf_en_d = 1'b1; // RQ9
		end
	end

	// Request computed on next state so it never asks for a full buffer
	// and never outlives a stop code or a cleared allow bit
	always_comb begin
		logic anyfree;
		anyfree = 1'b0;
		for (int i = 0; i < 8; i++) begin
			anyfree = anyfree | !buf_d[i].vld;
		end
		req_d = pf_en_d && allow_d && anyfree; // RQ22
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pf_en_q <= IPB_RST_PFEN;
			req_q <= 1'b0;
			cache_addr_q <= IPB_RST_ADDR;
		end else if (ce) begin
			pf_en_q <= pf_en_d;
			req_q <= req_d; // RQ7 RQ22
			cache_addr_q <= {addr_d[31:2], 2'b00};
		end
	end

	// Branch target: sign-extended byte 0; valid copies its valid bit
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bt_q <= 32'h0000_0000;
			bt_vld_q <= 1'b0;
		end else if (ce && ctl == IPB_BDEST) begin
			bt_q <= {{24{buf_q[0].dat[7]}}, buf_q[0].dat}; // RQ12
			bt_vld_q <= buf_q[0].vld;
		end
	end

	// Control write decode; the request reads the next allow value so a
	// cleared allow drops the request at the very edge the write lands
	assign ctrl_wr = wb_go && wb_we && wb_sel[0] && wb_adr[7:0] == IPB_REG_CTRL;
	assign allow_d = ctrl_wr ? wb_wdat[IPB_CTRL_ALLOW_BIT] : allow_q;

	// Wishbone classic slave: one wait state, ack drops after one cycle
	assign wb_go = wb_cyc && wb_stb && !ack_q;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			allow_q <= IPB_RST_ALLOW;
			rdat_q <= 32'h0000_0000;
		end else if (ce) begin
			ack_q <= wb_go;
			allow_q <= allow_d;
			if (wb_go && !wb_we) begin
				// Unmapped offsets read zero and are still acknowledged
				unique case (wb_adr[7:0])
					IPB_REG_CTRL: rdat_q <= {31'h0, allow_q};
					IPB_REG_STAT: rdat_q <= {22'h0, req_q, pf_en_q,
						buf_q[7].vld, buf_q[6].vld, buf_q[5].vld, buf_q[4].vld,
						buf_q[3].vld, buf_q[2].vld, buf_q[1].vld, buf_q[0].vld};
					IPB_REG_ADDR: rdat_q <= addr_q;
					IPB_REG_VFA: rdat_q <= vfa_q;
					IPB_REG_BLO: rdat_q <= {buf_q[3].dat, buf_q[2].dat, buf_q[1].dat, buf_q[0].dat};
					IPB_REG_BHI: rdat_q <= {buf_q[7].dat, buf_q[6].dat, buf_q[5].dat, buf_q[4].dat};
					default: rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Outputs straight from flip-flops
	assign cache_req = req_q;
	assign cache_addr = cache_addr_q;
	assign buf_out = buf_q;
	assign virtual_fetch_address = vfa_q;
	assign branch_target_extract = bt_q;
	assign branch_target_valid = bt_vld_q;
	assign wb_rdat = rdat_q;
	assign wb_ack = ack_q;

	// Checks; a cache fill in the same cycle would muddle the shift checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	chk_flush_clears: assert property (ce && flush |=> buf_q == '0 || buf_q != '0 && // RQ8
		(buf_q[0].vld | buf_q[1].vld | buf_q[2].vld | buf_q[3].vld |
		buf_q[4].vld | buf_q[5].vld | buf_q[6].vld | buf_q[7].vld) == 1'b0)
		else $error("flush left a valid section");
	chk_flush_addr: assert property (ce && flush |=> vfa_q == $past(new_fetch_addr) // RQ8
		&& addr_q == $past(new_fetch_addr))
		else $error("flush did not load fetch address");
	chk_stop_req: assert property (ce && ctl == IPB_STOP ##1 (!ce || ctl != IPB_START)[*2] // RQ7
		|-> !cache_req)
		else $error("request after stop");
	chk_start_en: assert property (ce && ctl == IPB_START |=> pf_en_q) // RQ9
		else $error("start did not enable prefetch");
	chk_nop_hold: assert property (ce && !take && (ctl == IPB_NOP || ctl == IPB_UNUSED6 || // RQ6 RQ21
		ctl == IPB_UNUSEDA) |=> buf_q == $past(buf_q) && pf_en_q == $past(pf_en_q))
		else $error("idle code changed the buffer");
	chk_clr0_shift: assert property (ce && !take && ctl == IPB_CLR0 |=> // RQ13
		buf_q[0] == $past(buf_q[1]) && buf_q[6] == $past(buf_q[7]) && !buf_q[7].vld)
		else $error("clear 0 shifted wrong");
	chk_clr01_shift: assert property (ce && !take && ctl == IPB_CLR01 |=> // RQ10
		buf_q[0] == $past(buf_q[2]) && buf_q[5] == $past(buf_q[7]))
		else $error("clear 0,1 shifted wrong");
	chk_clr23_keep: assert property (ce && !take && ctl == IPB_CLR23 |=> // RQ11
		buf_q[1] == $past(buf_q[1]) && buf_q[2] == $past(buf_q[4]))
		else $error("clear 2,3 shifted wrong");
	chk_clr1_keep: assert property (ce && !take && ctl == IPB_CLR1 |=> // RQ14
		buf_q[0] == $past(buf_q[0]) && buf_q[1] == $past(buf_q[2]))
		else $error("clear 1 shifted wrong");
	chk_clr0123_shift: assert property (ce && !take && ctl == IPB_CLR0123 |=> // RQ15
		buf_q[0] == $past(buf_q[4]) && buf_q[3] == $past(buf_q[7]))
		else $error("clear 0-3 shifted wrong");
	chk_cond_nodata: assert property (ce && !take && ctl == IPB_CLRCOND && // RQ17
		buf_q[1].dat[7:4] < 4'h8 |=> buf_q[1] == $past(buf_q[2]) && buf_q[0] == $past(buf_q[0]))
		else $error("conditional clear kept specifier");
	chk_cond_long: assert property (ce && !take && ctl == IPB_CLRCOND && // RQ16
		buf_q[1].dat[7:5] == 3'b111 |=> buf_q[1] == $past(buf_q[5]))
		else $error("conditional clear dropped wrong length");
	chk_req_cond: assert property (cache_req |-> pf_en_q && allow_q && // RQ22
		!(buf_q[0].vld & buf_q[1].vld & buf_q[2].vld & buf_q[3].vld &
		buf_q[4].vld & buf_q[5].vld & buf_q[6].vld & buf_q[7].vld))
		else $error("request while full or disabled");
	chk_fill_low: assert property (ce && take && ctl == IPB_NOP && !buf_q[0].vld |=> // RQ18 RQ20
		buf_q[0].vld && buf_q[0].dat == $past(rot[7:0]))
		else $error("fill did not place addressed byte");
	chk_branch: assert property (ce && ctl == IPB_BDEST |=> // RQ12
		branch_target_extract[7:0] == $past(buf_q[0].dat) && branch_target_extract[31] == $past(buf_q[0].dat[7]))
		else $error("branch target wrong");
	chk_freeze: assert property (!ce |=> buf_q == $past(buf_q) && cache_req == $past(cache_req)) // RQ3
		else $error("state moved while frozen");
	chk_cond_ctx: assert property (ce && !take && ctl == IPB_CLRCOND && // RQ16
		buf_q[1].dat == 8'h8F && stream_ctx_size == 2'b01 |=> buf_q[1] == $past(buf_q[3]))
		else $error("conditional clear ignored context size");
	chk_cond_defer: assert property (ce && !take && ctl == IPB_CLRCOND && // RQ16
		buf_q[1].dat == 8'h9F |=> buf_q[1] == $past(buf_q[5]))
		else $error("deferred literal not dropped as longword");
	chk_allow_req: assert property (ce && ctrl_wr && !wb_wdat[IPB_CTRL_ALLOW_BIT] |=> !cache_req) // RQ22
		else $error("request survived allow clear");

	cov_flush_fill: cover property (ce && flush ##[1:4] ce && take);
	cov_cond_clear: cover property (ce && !take && ctl == IPB_CLRCOND && buf_q[1].dat[7:4] == 4'hC);
	cov_full: cover property (ce && pf_en_q && !cache_req ##1 ce && ctl == IPB_CLR0123);
	cov_ctx_word: cover property (ce && ctl == IPB_CLRCOND && buf_q[1].dat == 8'h8F && stream_ctx_size == 2'b01);
	cov_frozen: cover property (!ce ##1 !ce);

endmodule
`default_nettype wire

// ===== rtl/ipb_pkg.sv
// Package for the instruction prefetch buffer: section type, control codes,
// register map, reset values and shared helper functions.
// Assumes a single 40 MHz clock domain shared by all users.
package ipb_pkg;

	// One buffer section: valid flag above eight data bits
	typedef struct packed {
		logic vld;
		logic [7:0] dat;
	} ipb_sect_t;

	// Section 0 holds the lowest memory address
	typedef ipb_sect_t [7:0] ipb_buf_t;

	// Microword buffer control codes
	typedef enum logic [3:0] {
		IPB_NOP = 4'b0000,
		IPB_STOP = 4'b0001,
		IPB_FLUSH = 4'b0010,
		IPB_START = 4'b0011,
		IPB_CLR01 = 4'b0100,
		IPB_CLR23 = 4'b0101,
		IPB_UNUSED6 = 4'b0110,
		IPB_BDEST = 4'b0111,
		IPB_UNUSED8 = 4'b1000,
		IPB_UNUSED9 = 4'b1001,
		IPB_UNUSEDA = 4'b1010,
		IPB_UNUSEDB = 4'b1011,
		IPB_CLR0 = 4'b1100,
		IPB_CLR1 = 4'b1101,
		IPB_CLR0123 = 4'b1110,
		IPB_CLRCOND = 4'b1111
	} ipb_ctl_t;

	// Shift network selects: 0, 1, 2 or 4 positions
	typedef enum logic [1:0] {
		IPB_SH0 = 2'b00,
		IPB_SH1 = 2'b01,
		IPB_SH2 = 2'b10,
		IPB_SH4 = 2'b11
	} ipb_shf_t;

	// Wishbone register byte offsets
	localparam logic [7:0] IPB_REG_CTRL = 8'h00;
	localparam logic [7:0] IPB_REG_STAT = 8'h04;
	localparam logic [7:0] IPB_REG_ADDR = 8'h08;
	localparam logic [7:0] IPB_REG_VFA = 8'h0C;
	localparam logic [7:0] IPB_REG_BLO = 8'h10;
	localparam logic [7:0] IPB_REG_BHI = 8'h14;

	// Field positions
	localparam int IPB_CTRL_ALLOW_BIT = 0;
	localparam int IPB_STAT_PFEN_BIT = 8;
	localparam int IPB_STAT_REQ_BIT = 9;

	// Reset values and size constants
	localparam logic IPB_RST_ALLOW = 1'b1;
	localparam logic IPB_RST_PFEN = 1'b1;
	localparam logic [31:0] IPB_RST_ADDR = 32'h0000_0000;
	localparam logic [3:0] IPB_BYTES_LW = 4'h4;
	localparam logic [3:0] IPB_NSECT = 4'h8;

	// Number of positions a shift select moves
	function automatic logic [3:0] ipb_shift_cnt(input ipb_shf_t s);
		logic [3:0] n;
		n = 4'h0;
		unique case (s)
			IPB_SH0: n = 4'h0;
			IPB_SH1: n = 4'h1;
			IPB_SH2: n = 4'h2;
			IPB_SH4: n = 4'h4;
		endcase
		return n;
	endfunction

	// Index of the lowest invalid section, 8 when all are valid
	function automatic logic [3:0] ipb_first_gap(input ipb_buf_t b);
		logic [3:0] n;
		n = IPB_NSECT;
		for (int i = 7; i >= 0; i--) begin
			if (!b[i].vld) begin
				n = 4'(i);
			end
		end
		return n;
	endfunction

endpackage

// ===== rtl/ipb_shifter.sv
// Shift network of the prefetch buffer: sections at or above a low mark
// move toward section 0; sections below it stay in place.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module ipb_shifter import ipb_pkg::*; (
	input wire ipb_buf_t cur,
	input wire logic [2:0] lo,
	input wire ipb_shf_t sel,
	output ipb_buf_t nxt
);

	// Four-input mux per section; bytes shifted in from beyond 7 are empty
	always_comb begin
		logic [3:0] k;
		logic [3:0] src;
		k = ipb_shift_cnt(sel);
		src = 4'h0;
		for (int i = 0; i < 8; i++) begin
			src = 4'(i) + k;
			if (4'(i) < {1'b0, lo}) begin
				nxt[i] = cur[i];
			end else if (src < IPB_NSECT) begin
				nxt[i] = cur[src[2:0]]; // RQ4
			end else begin
				nxt[i] = '0;
			end
		end
	end

endmodule
`default_nettype wire

// ===== rtl/ipb_rotator.sv
// Byte rotator between the cache longword and the buffer input mux.
// Assumes the offset is the low two bits of the byte fetch address.
`timescale 1ns/1ps
`default_nettype none
module ipb_rotator (
	input wire logic [31:0] lw,
	input wire logic [1:0] ofs,
	output logic [31:0] rot
);

	// Addressed byte lands in bits 7:0, the rest wrap around
	logic [63:0] dbl;
	assign dbl = {lw, lw} >> {ofs, 3'b000}; // RQ19 RQ20
	assign rot = dbl[31:0];

endmodule
`default_nettype wire

// ===== test/ipb_cache_model.sv
// Cache model for the prefetch buffer bench: grants longword requests.
// Assumes the buffer holds its request and reads data in the grant cycle.
`timescale 1ns/1ps
`default_nettype none
module ipb_cache_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic cache_req,
	input wire logic [31:0] cache_addr,
	output logic cache_grant,
	output logic [31:0] cache_data
);
	logic [1:0] wait_q;
	logic [31:0] lw;

	// Stall counter: in slow mode only every third cycle may grant
	always_ff @(posedge clk) begin
		if (!nrst || wait_q == 2'h2) begin
			wait_q <= 2'h0;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end

	// Each byte equals its low address byte, so contents are predictable
	assign lw = {cache_addr[7:0] + 8'h03, cache_addr[7:0] + 8'h02, cache_addr[7:0] + 8'h01, cache_addr[7:0]};
	assign cache_grant = cache_req && (!slow || wait_q == 2'h2);
	// Outside a grant the data is inverted junk, never the last good word
	assign cache_data = cache_grant ? lw : ~lw;
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the instruction prefetch buffer core.
// Assumes the cache model beside it and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top import ipb_pkg::*;;
	logic clk = 1'b0;
	logic nrst, slow, ce, cache_req, cache_grant, wb_cyc, wb_stb, wb_we, wb_ack, bt_vld;
	logic [3:0] ctl, wb_sel, sel_w;
	logic [1:0] ctx;
	logic [31:0] fetch_addr, cache_addr, cache_data, vfa, bt, wb_adr, wb_wdat, wb_rdat;
	ipb_buf_t buf_out;
	int miscompares, comparisons;
	int cycles = 0;
	// Code, low mark, shift count for plain discard and idle codes
	logic [11:0] plan [0:10] = '{12'h000, 12'h402, 12'h522, 12'h600, 12'h800, 12'h900,
		12'hA00, 12'hB00, 12'hC01, 12'hD11, 12'hE04};

	// Clock, design and cache model
	always #12.5 clk = ~clk;
	ipb_core dut_u (.clk(clk), .nrst(nrst), .ce(ce), .buffer_control_field(ctl),
		.new_fetch_addr(fetch_addr), .stream_ctx_size(ctx), .cache_grant(cache_grant),
		.cache_data(cache_data), .cache_req(cache_req), .cache_addr(cache_addr), .buf_out(buf_out),
		.virtual_fetch_address(vfa), .branch_target_extract(bt), .branch_target_valid(bt_vld),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack));
	ipb_cache_model cache_u (.clk(clk), .nrst(nrst), .slow(slow), .cache_req(cache_req),
		.cache_addr(cache_addr), .cache_grant(cache_grant), .cache_data(cache_data));

	// Hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [71:0] seen, input logic [71:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Full buffer image starting at byte address b
	function automatic logic [71:0] img(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			img[9*i +: 9] = {1'b1, b + 8'(i)};
		end
	endfunction

	// Sections from lo upward move down by n; the top fills with empty sections
	function automatic logic [71:0] shf(input logic [71:0] x, input int lo, input int n);
		shf = x;
		for (int i = lo; i < 8; i++) begin
			shf[9*i +: 9] = (i + n < 8) ? x[9*(i+n) +: 9] : 9'h000;
		end
	endfunction

	function automatic logic [7:0] vbits();
		for (int i = 0; i < 8; i++) begin
			vbits[i] = buf_out[i].vld;
		end
	endfunction

	// One control code for one edge, then back to idle
	task automatic step(input logic [3:0] c);
		@(posedge clk);
		ctl <= c;
		@(posedge clk);
		ctl <= IPB_NOP;
	endtask

	// Reads sample the values settled before each edge, so the loop is race free
	task automatic wait_full();
		int n;
		n = 0;
		while (n < 60 && vbits() !== 8'hFF) begin
			@(posedge clk);
			n++;
		end
		chk("buffer fill", vbits(), 8'hFF);
	endtask

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {24'h000000, adr};
		wb_wdat <= wd;
		wb_sel <= sel_w;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		rd = wb_rdat;
		chk("bus ack", wb_ack, 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	// Flush to b, fill completely, then stop prefetch so nothing refills
	task automatic prep(input logic [7:0] b);
		fetch_addr <= {24'h000000, b};
		step(IPB_FLUSH);
		step(IPB_START);
		wait_full();
		step(IPB_STOP);
		@(posedge clk);
	endtask

	task automatic t_reset();
		@(posedge clk);
		chk("buffer at reset", buf_out, 72'h0);
		chk("request at reset", cache_req, 1'b0);
		@(posedge clk);
		chk("request after release", cache_req, 1'b1);
		wait_full();
		chk("first fill", buf_out, img(8'h00));
		chk("request when full", cache_req, 1'b0);
	endtask

	task automatic t_discard();
		for (int k = 0; k < 11; k++) begin
			prep(8'h10);
			step(plan[k][11:8]);
			@(posedge clk);
			chk("discard", buf_out, shf(img(8'h10), plan[k][7:4], plan[k][3:0]));
		end
	endtask

	// Section 1 byte picks the mode: A, C, E carry data, 5 carries none;
	// 9F is a deferred longword, 8F takes its length from the context size
	task automatic t_cond();
		logic [15:0] fp [0:7];
		fp = '{16'h09F1, 16'h0BF2, 16'h0DF4, 16'h04F1, 16'h09E4, 16'h08E1, 16'h18E2, 16'h28E4};
		for (int k = 0; k < 8; k++) begin
			ctx <= fp[k][13:12];
			prep(fp[k][11:4]);
			step(IPB_CLRCOND);
			@(posedge clk);
			chk("conditional discard", buf_out, shf(img(fp[k][11:4]), 1, fp[k][3:0]));
		end
	endtask

	task automatic t_branch();
		prep(8'h80);
		step(IPB_BDEST);
		@(posedge clk);
		chk("branch target", bt, 32'hFFFF_FF80);
		chk("branch valid", bt_vld, 1'b1);
		chk("buffer kept", buf_out, img(8'h80));
	endtask

	task automatic t_stopstart();
		prep(8'h31);
		step(IPB_CLR0);
		repeat (3) @(posedge clk);
		chk("request while stopped", cache_req, 1'b0);
		step(IPB_START);
		@(posedge clk);
		chk("request after start", cache_req, 1'b1);
		wait_full();
		chk("refill", buf_out, img(8'h32));
	endtask

	// Slow cache and an unaligned flush address
	task automatic t_slow();
		slow <= 1'b1;
		fetch_addr <= 32'h0000_0021;
		step(IPB_FLUSH);
		@(posedge clk);
		chk("flush valid", vbits(), 8'h00);
		chk("fetch address", vfa, 32'h0000_0021);
		step(IPB_START);
		wait_full();
		chk("slow fill", buf_out, img(8'h21));
		slow <= 1'b0;
	endtask

	// Clock enable low: a discard code is held off and nothing moves
	task automatic t_freeze();
		prep(8'h50);
		@(posedge clk);
		ce <= 1'b0;
		ctl <= IPB_CLR0123;
		repeat (4) @(posedge clk);
		chk("frozen buffer", buf_out, img(8'h50));
		chk("frozen request", cache_req, 1'b0);
		ce <= 1'b1;
		ctl <= IPB_NOP;
		@(posedge clk);
	endtask

	task automatic t_bus();
		logic [31:0] rd;
		wb(1'b0, IPB_REG_CTRL, 32'h0, rd);
		chk("control reset", rd, 32'h0000_0001);
		sel_w = 4'hE;
		wb(1'b1, IPB_REG_CTRL, 32'h0, rd);
		sel_w = 4'hF;
		wb(1'b0, IPB_REG_CTRL, 32'h0, rd);
		chk("control masked write", rd, 32'h0000_0001);
		wb(1'b1, IPB_REG_CTRL, 32'h0, rd);
		fetch_addr <= 32'h0000_0040;
		step(IPB_FLUSH);
		step(IPB_START);
		repeat (3) @(posedge clk);
		chk("request blocked", cache_req, 1'b0);
		wb(1'b0, IPB_REG_STAT, 32'h0, rd);
		chk("status empty", rd, 32'h0000_0100);
		wb(1'b0, 8'h20, 32'h0, rd);
		chk("unmapped read", rd, 32'h0);
		wb(1'b1, IPB_REG_CTRL, 32'h1, rd);
		wait_full();
		wb(1'b0, IPB_REG_STAT, 32'h0, rd);
		chk("status full", rd, 32'h0000_01FF);
		wb(1'b0, IPB_REG_VFA, 32'h0, rd);
		chk("fetch address read", rd, 32'h0000_0040);
		wb(1'b0, IPB_REG_BLO, 32'h0, rd);
		chk("low bytes", rd, 32'h4342_4140);
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		slow = 1'b0;
		ctl = IPB_NOP;
		ce = 1'b1;
		ctx = 2'b00;
		wb_sel = 4'hF;
		sel_w = 4'hF;
		fetch_addr = 32'h0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 32'h0;
		wb_wdat = 32'h0;
		miscompares = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_discard();
		t_cond();
		t_branch();
		t_stopstart();
		t_slow();
		t_freeze();
		t_bus();
		results();
	end
endmodule
`default_nettype wire
